// file: hdl/ncq_abort_consts.svh
// Constants for the queue-abort command path
`ifndef NCQ_ABORT_CONSTS_SVH
`define NCQ_ABORT_CONSTS_SVH
`define CMD_NCQ_NON_DATA 8'h63
`define SUBCMD_QUEUE_ABORT 4'h0
`define SCOPE_ALL 4'h0
`define SCOPE_STREAMING 4'h1
`define SCOPE_NON_STREAMING 4'h2
`define SCOPE_SELECTED 4'h3
`define FEAT_SUBCMD_LSB 0
`define FEAT_SCOPE_LSB 4
`define SLOT_FIELD_LSB 3
`define DEVHEAD_ONE_BIT 6
`define DEVHEAD_ZERO_BIT 4
`define ERR_ABORTED_BIT 2
`define STS_BUSY_BIT 7
`define STS_READY_BIT 6
`define STS_FAULT_BIT 5
`define STS_SEEK_DONE_BIT 4
`define STS_XFER_REQ_BIT 3
`define STS_ERROR_BIT 0
`define FLAGS_RESET 8'h00
`define DEFAULT_QUEUE_DEPTH 32
`endif

// file: hdl/ncq_abort_pkg.sv
// Types shared by both ends of the queue-abort path
package ncq_abort_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b10
    } dev_state_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_WAIT = 2'b01
    } host_state_t;
endpackage

// file: hdl/ncq_abort_if.sv
// Link between host controller and device for queued non-data commands
`timescale 1ns/100ps
interface ncq_abort_if #(parameter int SLOTS = 32);
    logic cmd_valid;
    logic [7:0] command;
    logic [7:0] feature;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] device_head;
    logic sdb_valid;
    logic [SLOTS-1:0] active_slot_bits;
    logic [7:0] device_condition_flags;
    logic [7:0] command_failure_flags;
    modport device (
        input cmd_valid, command, feature, sector_count, sector_number,
        input device_head,
        output sdb_valid, active_slot_bits, device_condition_flags,
        output command_failure_flags
    );
    modport host (
        output cmd_valid, command, feature, sector_count, sector_number,
        output device_head,
        input sdb_valid, active_slot_bits, device_condition_flags,
        input command_failure_flags
    );
endinterface

// file: hdl/ncq_abort_host.sv
// Host end: issues the queue-abort subcommand and catches its completion
`timescale 1ns/100ps
`include "ncq_abort_consts.svh"
module ncq_abort_host #(
    parameter int SLOTS = `DEFAULT_QUEUE_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    ncq_abort_if.host link,
    input wire logic req_valid_i,
    input wire logic [3:0] req_scope_i,
    input wire logic [4:0] req_own_slot_i,
    input wire logic [4:0] req_victim_slot_i,
    output logic req_ready_o,
    output logic done_o,
    output logic failed_o,
    output logic [SLOTS-1:0] done_slots_o
);
    initial
    begin
        if (SLOTS < 1 || SLOTS > 32)
            $error("SLOTS must be 1 to 32");
    end

    ncq_abort_pkg::host_state_t state_q, state_d;
    logic [7:0] feat_q, count_q, number_q;
    logic done_q, failed_q;
    logic [SLOTS-1:0] done_slots_q;
    wire logic take = req_valid_i && (state_q == ncq_abort_pkg::HS_IDLE);

    assign req_ready_o = (state_q == ncq_abort_pkg::HS_IDLE);
    assign link.cmd_valid = (state_q == ncq_abort_pkg::HS_WAIT);
    assign link.command = `CMD_NCQ_NON_DATA;
    assign link.feature = feat_q;
    assign link.sector_count = count_q;
    assign link.sector_number = number_q;
    // Bit 6 one, bit 4 zero, rest zero
    assign link.device_head = 8'h40;
    assign done_o = done_q;
    assign failed_o = failed_q;
    assign done_slots_o = done_slots_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ncq_abort_pkg::HS_IDLE:
                if (take)
                    state_d = ncq_abort_pkg::HS_WAIT;
            ncq_abort_pkg::HS_WAIT:
                if (link.sdb_valid)
                    state_d = ncq_abort_pkg::HS_IDLE;
            default:
                state_d = ncq_abort_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= ncq_abort_pkg::HS_IDLE;
            feat_q <= 8'h00;
            count_q <= 8'h00;
            number_q <= 8'h00;
            done_q <= 1'b0;
            failed_q <= 1'b0;
            done_slots_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            done_q <= (state_q == ncq_abort_pkg::HS_WAIT) && link.sdb_valid;
            if (take)
            begin
                feat_q <= {req_scope_i, `SUBCMD_QUEUE_ABORT};
                count_q <= {req_own_slot_i, 3'h0};
                number_q <= {req_victim_slot_i, 3'h0};
            end
            if ((state_q == ncq_abort_pkg::HS_WAIT) && link.sdb_valid)
            begin
                failed_q <=
                    link.device_condition_flags[`STS_ERROR_BIT];
                done_slots_q <= link.active_slot_bits;
            end
        end
    end
endmodule // ncq_abort_host

// file: hdl/ncq_abort_device.sv
// Device end: decodes and executes the queue-abort subcommand
//
// Function
// - Command 63h routed by feature low nibble
// - Feature low nibble 0h selects queue abort
// - Feature high nibble holds abort scope
// - Scope 0h aborts every outstanding command except its own slot
// - Scope 1h aborts streaming commands only
// - Scope 2h aborts non-streaming commands only
// - Scope 3h aborts the matching victim slot
// - Host puts own slot in count bits 7-3
// - Host puts victim slot in number bits 7-3
// - Victim slot within reported queue depth
// - Victim slot ignored unless scope is 3h
// - Supported scope succeeds even aborting nothing
// - Completion frame flags own and aborted slots
// - Completion frame may carry other finished slots
// - Queuing disabled gives aborted-command error
// - Victim equal to own slot gives error
// - Invalid victim slot gives error
// - Unsupported scope gives error
// - Supported scopes published for the log page
`timescale 1ns/100ps
`include "ncq_abort_consts.svh"
module ncq_abort_device #(
    parameter int SLOTS = `DEFAULT_QUEUE_DEPTH,
    parameter logic [15:0] SUPPORTED_SCOPES = 16'h000f
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    ncq_abort_if.device link,
    input wire logic queuing_enabled_i,
    input wire logic [SLOTS-1:0] outstanding_i,
    input wire logic [SLOTS-1:0] streaming_i,
    input wire logic [SLOTS-1:0] finished_i,
    output logic [SLOTS-1:0] abort_slots_o,
    output logic abort_strobe_o,
    output logic [15:0] supported_scopes_o,
    output logic [7:0] status_o,
    output logic [7:0] error_o
);
    initial
    begin
        if (SLOTS < 1 || SLOTS > 32)
            $error("SLOTS must be 1 to 32");
    end

    ncq_abort_pkg::dev_state_t state_q, state_d;
    logic [7:0] feat_q, count_q, number_q;
    logic [SLOTS-1:0] abort_q, act_q;
    logic sdb_q, fail_q;
    logic [7:0] status_q, error_q;

    // Slot field sits in bits 7-3 of a byte
    function automatic logic [4:0] slot_of(input logic [7:0] b);
        slot_of = b[7:`SLOT_FIELD_LSB];
    endfunction

    // One bit per slot index; slots beyond SLOTS drop out
    function automatic logic [SLOTS-1:0] one_hot(input logic [4:0] s);
        logic [SLOTS-1:0] r;
        r = '0;
        for (int i = 0; i < SLOTS; i++)
            if (s == 5'(i))
                r[i] = 1'b1;
        one_hot = r;
    endfunction

    wire logic is_abort_cmd = link.cmd_valid &&
        (link.command == `CMD_NCQ_NON_DATA) &&
        (link.feature[3:0] == `SUBCMD_QUEUE_ABORT);
    wire logic start = is_abort_cmd && (state_q == ncq_abort_pkg::ST_IDLE);
    wire logic [3:0] scope = feat_q[7:`FEAT_SCOPE_LSB];
    wire logic [4:0] own_slot = slot_of(count_q);
    wire logic [4:0] victim_slot = slot_of(number_q);
    wire logic is_selected = (scope == `SCOPE_SELECTED);
    // Depth check also covers the reported queue depth limit
    wire logic victim_bad = is_selected &&
        (32'(victim_slot) >= SLOTS);
    wire logic victim_self = is_selected &&
        (victim_slot == own_slot);
    wire logic scope_bad = !SUPPORTED_SCOPES[scope] ||
        (scope > `SCOPE_SELECTED);
    wire logic fail = !queuing_enabled_i || scope_bad ||
        victim_bad || victim_self;
    wire logic [SLOTS-1:0] others = outstanding_i & ~one_hot(own_slot);
    logic [SLOTS-1:0] victims;

    always_comb
    begin
        victims = '0;
        case (scope)
            `SCOPE_ALL: victims = others;
            `SCOPE_STREAMING: victims = others & streaming_i;
            `SCOPE_NON_STREAMING:
                victims = others & ~streaming_i;
            `SCOPE_SELECTED:
                victims = others & one_hot(victim_slot);
            default: victims = '0;
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ncq_abort_pkg::ST_IDLE:
                if (start)
                    state_d = ncq_abort_pkg::ST_EXEC;
            ncq_abort_pkg::ST_EXEC:
                state_d = ncq_abort_pkg::ST_DONE;
            ncq_abort_pkg::ST_DONE:
                state_d = ncq_abort_pkg::ST_IDLE;
            default:
                state_d = ncq_abort_pkg::ST_IDLE;
        endcase
    end

    wire logic exec = (state_q == ncq_abort_pkg::ST_EXEC);
    // Status: busy, fault, request cleared; ready and seek-done set
    wire logic [7:0] status_done = (8'h01 << `STS_READY_BIT) |
        (8'h01 << `STS_SEEK_DONE_BIT) |
        ({7'h00, fail} << `STS_ERROR_BIT);

    assign link.sdb_valid = sdb_q;
    assign link.active_slot_bits = act_q;
    assign link.device_condition_flags = status_q;
    assign link.command_failure_flags = error_q;
    assign abort_slots_o = abort_q;
    assign abort_strobe_o = sdb_q && !fail_q;
    assign supported_scopes_o = SUPPORTED_SCOPES;
    assign status_o = status_q;
    assign error_o = error_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= ncq_abort_pkg::ST_IDLE;
            feat_q <= 8'h00;
            count_q <= 8'h00;
            number_q <= 8'h00;
            abort_q <= '0;
            act_q <= '0;
            sdb_q <= 1'b0;
            fail_q <= 1'b0;
            status_q <= `FLAGS_RESET;
            error_q <= `FLAGS_RESET;
        end
        else
        begin
            state_q <= state_d;
            sdb_q <= exec;
            if (start)
            begin
                feat_q <= link.feature;
                count_q <= link.sector_count;
                number_q <= link.sector_number;
                status_q <= 8'h01 << `STS_BUSY_BIT;
            end
            if (exec)
            begin
                fail_q <= fail;
                // Success even when victims is empty
                abort_q <= fail ? '0 : victims;
                act_q <= one_hot(own_slot) | (fail ? '0 : victims) |
                    (finished_i & outstanding_i);
                status_q <= status_done;
                error_q <= {5'h00, fail, 2'h0};
            end
        end
    end
endmodule // ncq_abort_device

// file: testbench/ncq_abort_asserts.sv
// Concurrent checks on the link between host and device ends
`timescale 1ns/100ps
module ncq_abort_asserts #(
    parameter int SLOTS = 32
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic cmd_valid,
    input wire logic [7:0] command,
    input wire logic [7:0] feature,
    input wire logic [7:0] sector_count,
    input wire logic [7:0] sector_number,
    input wire logic [7:0] device_head,
    input wire logic sdb_valid,
    input wire logic [SLOTS-1:0] active_slot_bits,
    input wire logic [7:0] device_condition_flags,
    input wire logic [7:0] command_failure_flags
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    wire is_abort = command == 8'h63 && feature[3:0] == 4'h0;
    a_take_gets_frame: assert property ($rose(cmd_valid) && is_abort |->
        ##[1:3] sdb_valid)
        else $error("no completion frame after abort command");
    a_busy_after_take: assert property ($rose(cmd_valid) && is_abort |=>
        device_condition_flags[7])
        else $error("busy not shown while executing");
    a_frame_one_cycle: assert property (sdb_valid |=> !sdb_valid)
        else $error("completion frame longer than one cycle");
    a_hold_until_frame: assert property (cmd_valid && !sdb_valid |=> cmd_valid)
        else $error("command dropped before completion");
    a_own_slot_set: assert property (sdb_valid |->
        active_slot_bits[sector_count[7:3]])
        else $error("own slot missing from completion");
    a_status_clean: assert property (sdb_valid |->
        (device_condition_flags & 8'ha8) == 8'h00)
        else $error("busy, fault or request left set");
    a_error_pairs_abt: assert property (sdb_valid |->
        device_condition_flags[0] == command_failure_flags[2])
        else $error("error bit and aborted bit disagree");
    a_bad_scope_err: assert property (sdb_valid && feature[7:4] > 4'h3 |->
        device_condition_flags[0])
        else $error("unsupported scope completed without error");
    a_victim_own_err: assert property (sdb_valid && feature[7:4] == 4'h3 &&
        sector_number[7:3] == sector_count[7:3] |->
        device_condition_flags[0])
        else $error("victim equal to own slot not refused");
    a_head_bits: assert property (cmd_valid |->
        device_head[6] && !device_head[4])
        else $error("device/head bits wrong");
endmodule // ncq_abort_asserts

// file: testbench/testbench.sv
// Bench joining host and device ends over the queued-command link
`timescale 1ns/100ps
module testbench;
    logic clk_sys_i;
    logic arst_n_i;
    logic req_valid;
    logic [3:0] req_scope;
    logic [4:0] req_own;
    logic [4:0] req_victim;
    logic qen;
    logic [15:0] outs;
    logic [15:0] strm;
    logic [15:0] fin;
    logic ready;
    logic done;
    logic failed;
    logic [15:0] done_slots;
    logic [15:0] abort_slots;
    logic [15:0] scopes;
    logic [7:0] status;
    logic [7:0] error;
    int failures;
    int n_tests;
    int tnum;
    // Sixteen slots so a five-bit victim can point past the queue
    ncq_abort_if #(.SLOTS(16)) link ();
    ncq_abort_host #(.SLOTS(16)) i_ncq_abort_host (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .link(link), .req_valid_i(req_valid),
        .req_scope_i(req_scope), .req_own_slot_i(req_own),
        .req_victim_slot_i(req_victim), .req_ready_o(ready), .done_o(done),
        .failed_o(failed), .done_slots_o(done_slots));
    ncq_abort_device #(.SLOTS(16)) i_ncq_abort_device (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .link(link), .queuing_enabled_i(qen),
        .outstanding_i(outs), .streaming_i(strm), .finished_i(fin),
        .abort_slots_o(abort_slots), .abort_strobe_o(),
        .supported_scopes_o(scopes), .status_o(status), .error_o(error));
    ncq_abort_asserts #(.SLOTS(16)) i_ncq_abort_asserts (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .cmd_valid(link.cmd_valid), .command(link.command),
        .feature(link.feature), .sector_count(link.sector_count),
        .sector_number(link.sector_number), .device_head(link.device_head),
        .sdb_valid(link.sdb_valid), .active_slot_bits(link.active_slot_bits),
        .device_condition_flags(link.device_condition_flags),
        .command_failure_flags(link.command_failure_flags));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [3:0] sc, input logic [4:0] own,
        input logic [4:0] vic, input logic en, input logic [15:0] o,
        input logic [15:0] s, input logic [15:0] f, input logic bad);
        logic [15:0] vict;
        logic [15:0] act;
        logic seen;
        vict = sc == 4'h0 ? o : sc == 4'h1 ? o & s : sc == 4'h2 ? o & ~s :
            o & (16'h0001 << vic);
        vict = vict & ~(16'h0001 << own);
        act = bad ? 16'h0001 << own : vict | (16'h0001 << own) | (f & o);
        seen = 1'b0;
        {req_scope, req_own, req_victim, qen} = {sc, own, vic, en};
        {outs, strm, fin} = {o, s, f};
        req_valid = 1'b1;
        @(posedge clk_sys_i);
        #1 req_valid = 1'b0;
        for (int i = 0; i < 20 && done !== 1'b1; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            if (link.cmd_valid === 1'b1 && !seen)
            begin
                seen = 1'b1;
                chk({link.command, link.feature}, {8'h63, sc, 4'h0});
                chk(link.sector_count[7:3], own);
                chk(link.sector_number[7:3], vic);
                chk({link.device_head[6], link.device_head[4]}, 2'b10);
            end
        end
        chk(done, 1'b1);
        chk(failed, bad);
        chk(done_slots, act);
        chk(status, bad ? 8'h51 : 8'h50);
        chk(error, bad ? 8'h04 : 8'h00);
        if (!bad && f == 16'h0000)
            chk(abort_slots, vict);
        tnum++;
        $display("test %0d done", tnum);
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("%0d checks, %0d failures", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        // Generous span; the whole sequence needs under two hundred cycles
        repeat (3000) @(posedge clk_sys_i);
        failures++;
        $display("CHECK FAILED at %0t: run hung", $time);
        wrap_up();
    end
    initial
    begin
        {arst_n_i, req_valid, req_scope, req_own, req_victim} = '0;
        {qen, outs, strm, fin} = '0;
        repeat (2) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        chk(scopes, 16'h000f);
        run(4'h0, 5'd1, 5'd1, 1'b1, 16'h00f6, 16'h0030, 16'h0, 1'b0);
        run(4'h1, 5'd2, 5'd0, 1'b1, 16'h00f0, 16'h0030, 16'h0, 1'b0);
        run(4'h2, 5'd3, 5'd0, 1'b1, 16'h00f0, 16'h0030, 16'h0, 1'b0);
        run(4'h3, 5'd4, 5'd6, 1'b1, 16'h00f0, 16'h0, 16'h0, 1'b0);
        run(4'h3, 5'd4, 5'd9, 1'b1, 16'h00f0, 16'h0, 16'h0, 1'b0);
        run(4'h1, 5'd5, 5'd0, 1'b1, 16'h0f00, 16'h0, 16'h0, 1'b0);
        run(4'h1, 5'd7, 5'd0, 1'b1, 16'h0300, 16'h0, 16'h0100, 1'b0);
        run(4'h0, 5'd2, 5'd0, 1'b0, 16'h00f0, 16'h0, 16'h0, 1'b1);
        run(4'h3, 5'd4, 5'd4, 1'b1, 16'h00f0, 16'h0, 16'h0, 1'b1);
        run(4'h3, 5'd4, 5'd20, 1'b1, 16'h00f0, 16'h0, 16'h0, 1'b1);
        for (int sc = 4; sc < 16; sc++)
            run(sc[3:0], 5'd1, 5'd0, 1'b1, 16'h00f0, 16'h0, 16'h0, 1'b1);
        wrap_up();
    end
endmodule // testbench
